// >>> rtl/crtctv_pkg.sv
package crtctv_pkg;

	// ---------------------------------------------------------------
	// register indices (crtc data port)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_ILACE_RETRACE = 8'h31;
	localparam logic [7:0] IDX_TV_VDE_START  = 8'h32;
	localparam logic [7:0] IDX_TV_VDE_ENDHI  = 8'h33;
	localparam logic [7:0] IDX_TV_VDE_ENDLO  = 8'h34;
	localparam logic [7:0] IDX_VEXP_LO       = 8'h35;
	localparam logic [7:0] IDX_VEXP_HI       = 8'h36;
	localparam logic [7:0] IDX_EQ_CTRL       = 8'h38;
	localparam logic [7:0] IDX_SERR_CTRL     = 8'h39;
	localparam logic [7:0] IDX_FINE_TUNE     = 8'h3a;
	localparam logic [7:0] IDX_TEST_TWO      = 8'h3b;
	localparam logic [7:0] IDX_TEST_THREE    = 8'h3c;
	localparam logic [7:0] REG_RESET         = 8'h00;

	// ---------------------------------------------------------------
	// io ports (low 12 bits of the host io address)
	// ---------------------------------------------------------------
	localparam logic [11:0] PORT_IDX_MONO  = 12'h3b4;
	localparam logic [11:0] PORT_DATA_MONO = 12'h3b5;
	localparam logic [11:0] PORT_IDX_COLOR = 12'h3d4;
	localparam logic [11:0] PORT_DATA_COLOR = 12'h3d5;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int ILACE_TIME_BIT = 7;
	localparam int HBLANK_TOP_HI  = 6;
	localparam int HBLANK_TOP_LO  = 5;
	localparam int VBLANK_TOP_HI  = 4;
	localparam int VBLANK_TOP_LO  = 3;
	localparam int VDE_END_HI     = 2;
	localparam int CSYNC_SRC_BIT  = 7;
	localparam int EQW_HI         = 5;
	localparam int SERR_HI        = 5;
	localparam int HSDLY_HI       = 5;
	localparam int HSDLY_LO       = 3;
	localparam int CDOT_HI        = 2;
	localparam int DBG_SEL_HI     = 7;
	localparam int DBG_SEL_LO     = 6;
	localparam int BLANK_SEL_BIT  = 5;
	localparam int LC_IGNORE_BIT  = 4;
	localparam int DBG_TEST_HI    = 3;

	// ---------------------------------------------------------------
	// timing constants
	// ---------------------------------------------------------------
	localparam int          PULSE_UNIT   = 4;  // video clocks per unit
	localparam logic [2:0]  HSDLY_MAX    = 3'h5;
	localparam logic [2:0]  CDOT_MIN     = 3'h2;
	localparam logic [3:0]  FULL_CHAR    = 4'h8;

	typedef enum logic [1:0] {
		CRTCTV_EQ_IDLE = 2'b00,
		CRTCTV_EQ_PULSE = 2'b01,
		CRTCTV_EQ_GAP = 2'b10
	} crtctv_eq_t;

endpackage

// >>> rtl/crtctv_timing.sv
// What this block does
// - in interlace, vertical retrace starts at char count from retrace reg
// - retrace position used only while interlace mode is enabled
// - tv vertical display enable asserts when line count equals start value
// - tv vertical display enable drops when line count equals 11-bit end
// - bit 7 of end-high reg enables interlace timing for double-scan
// - hblank end built from end-high 6:5 and std hblank end input bits 5:0
// - vblank end 10 bits from end-high 4:3 and crtc index 16
// - 10-bit expansion constant held; software sets expanded vertical size
// - text expansion repeats last row per constant bits 2:0 only
// - composite sync is hsync nor vsync, or equalizer output
// - serration pulse width is field times four video clocks
// - hsync delayed zero to five pixel clocks per delay field
// - short character clock holds two to seven dots
// - line is full 8-dot characters plus one short final character
// - blank select 0 sends inverse of active display, border ignored
// - blank select 1 sends crt blank, border where both inactive
// - line compare select 1 ignores line compare bits 9:8
// - test register selects debug bus; 4-bit field reserved
// - all registers in this group reset to zero
// - expansion without table uses constant registers as dda value
module crtctv_timing
	import crtctv_pkg::*;
#(
	parameter int HCNT_W = 8,
	parameter int VCNT_W = 11
) (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// host io access
	input  wire logic [11:0]       io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [7:0]        io_wdata,
	output logic      [7:0]        io_rdata,
	output logic                   io_hit,
	input  wire logic              misc_color_sel,
	// standard crtc and mode inputs
	input  wire logic              interlace_enable,
	input  wire logic [7:0]        crtc_hblank_end_std,
	input  wire logic [7:0]        crtc_vblank_end_std,
	input  wire logic [9:0]        crtc_line_compare_std,
	input  wire logic              vexpand_enable,
	input  wire logic              vexpand_table_sel,
	input  wire logic              text_mode,
	// timing inputs from main crtc counters
	input  wire logic [HCNT_W-1:0] char_count,
	input  wire logic              char_last,
	input  wire logic [VCNT_W-1:0] line_count,
	input  wire logic              hsync_in,
	input  wire logic              vsync_in,
	input  wire logic              crt_blank,
	input  wire logic              disp_en,
	input  wire logic [15:0]       debug_bus_a,
	input  wire logic [15:0]       debug_bus_b,
	input  wire logic [15:0]       debug_bus_c,
	input  wire logic [15:0]       debug_bus_d,
	// outputs
	output logic                   interlace_retrace_start,
	output logic                   interlace_timing_enable,
	output logic                   tv_vdisp_en,
	output logic [7:0]             hblank_end_value,
	output logic [9:0]             vblank_end_value,
	output logic [9:0]             dda_value,
	output logic [2:0]             text_row_repeat,
	output logic                   dda_from_constant,
	output logic                   csync_out,
	output logic                   hsync_out,
	output logic                   char_clk_en,
	output logic                   dac_blank,
	output logic                   border_sel,
	output logic [9:0]             line_compare_value,
	output logic [15:0]            debug_out
);

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	logic [7:0] idx_q;
	logic [7:0] ilace_q, vstart_q, endhi_q, endlo_q;
	logic [7:0] vexlo_q, vexhi_q, eq_q, serr_q, fine_q, test2_q, test3_q;
	logic       sel_idx, sel_data;

	// base follows the misc address select, like standard vga
	always_comb begin
		sel_idx  = misc_color_sel ? (io_addr == PORT_IDX_COLOR)
		                          : (io_addr == PORT_IDX_MONO);
		sel_data = misc_color_sel ? (io_addr == PORT_DATA_COLOR)
		                          : (io_addr == PORT_DATA_MONO);
	end

	// index latch then data access
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			idx_q <= REG_RESET;
		end else if (io_wr && sel_idx) begin
			idx_q <= io_wdata;
		end
	end

	// all extended registers clear at power-on
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ilace_q  <= REG_RESET;
			vstart_q <= REG_RESET;
			endhi_q  <= REG_RESET;
			endlo_q  <= REG_RESET;
			vexlo_q  <= REG_RESET;
			vexhi_q  <= REG_RESET;
			eq_q     <= REG_RESET;
			serr_q   <= REG_RESET;
			fine_q   <= REG_RESET;
			test2_q  <= REG_RESET;
			test3_q  <= REG_RESET;
		end else if (io_wr && sel_data) begin
			case (idx_q)
				IDX_ILACE_RETRACE: ilace_q  <= io_wdata;
				IDX_TV_VDE_START:  vstart_q <= io_wdata;
				IDX_TV_VDE_ENDHI:  endhi_q  <= io_wdata;
				IDX_TV_VDE_ENDLO:  endlo_q  <= io_wdata;
				IDX_VEXP_LO:       vexlo_q  <= io_wdata;
				IDX_VEXP_HI:       vexhi_q  <= {6'h00, io_wdata[1:0]};
				IDX_EQ_CTRL:       eq_q     <= {io_wdata[7], 1'b0,
				                                io_wdata[5:0]};
				IDX_SERR_CTRL:     serr_q   <= {2'h0, io_wdata[5:0]};
				IDX_FINE_TUNE:     fine_q   <= {2'h0, io_wdata[5:0]};
				IDX_TEST_TWO:      test2_q  <= io_wdata;
				IDX_TEST_THREE:    test3_q  <= io_wdata;
				default: ;
			endcase
		end
	end

	// read mux; reserved bits were stored as zero
	always_comb begin
		io_hit = (io_rd || io_wr) && (sel_idx || sel_data);
		io_rdata = 8'h00;
		if (sel_idx) begin
			io_rdata = idx_q;
		end else if (sel_data) begin
			case (idx_q)
				IDX_ILACE_RETRACE: io_rdata = ilace_q;
				IDX_TV_VDE_START:  io_rdata = vstart_q;
				IDX_TV_VDE_ENDHI:  io_rdata = endhi_q;
				IDX_TV_VDE_ENDLO:  io_rdata = endlo_q;
				IDX_VEXP_LO:       io_rdata = vexlo_q;
				IDX_VEXP_HI:       io_rdata = vexhi_q;
				IDX_EQ_CTRL:       io_rdata = eq_q;
				IDX_SERR_CTRL:     io_rdata = serr_q;
				IDX_FINE_TUNE:     io_rdata = fine_q;
				IDX_TEST_TWO:      io_rdata = test2_q;
				IDX_TEST_THREE:    io_rdata = test3_q;
				default:           io_rdata = 8'h00;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// combined values
	// ---------------------------------------------------------------
	logic [9:0] vexpand_constant;
	assign vexpand_constant = {vexhi_q[1:0], vexlo_q};
	assign interlace_timing_enable = endhi_q[ILACE_TIME_BIT];
	assign hblank_end_value = {endhi_q[HBLANK_TOP_HI:HBLANK_TOP_LO],
	                           crtc_hblank_end_std[5:0]};
	assign vblank_end_value = {endhi_q[VBLANK_TOP_HI:VBLANK_TOP_LO],
	                           crtc_vblank_end_std};
	// dda takes all 10 bits in either mode, text row repeat only 2:0
	assign dda_from_constant = vexpand_enable && !vexpand_table_sel;
	assign dda_value = dda_from_constant ? vexpand_constant : 10'h000;
	assign text_row_repeat = (text_mode && vexpand_enable)
	                         ? vexpand_constant[2:0] : 3'h0;
	assign line_compare_value = test3_q[LC_IGNORE_BIT]
	    ? {2'b00, crtc_line_compare_std[7:0]} : crtc_line_compare_std;

	// debug bus selection
	always_comb begin
		case (test3_q[DBG_SEL_HI:DBG_SEL_LO])
			2'b00:   debug_out = debug_bus_a;
			2'b01:   debug_out = debug_bus_b;
			2'b10:   debug_out = debug_bus_c;
			default: debug_out = debug_bus_d;
		endcase
	end

	// ---------------------------------------------------------------
	// interlace retrace and tv display enable
	// ---------------------------------------------------------------
	// retrace point only matters with interlace on
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			interlace_retrace_start <= 1'b0;
		end else begin
			interlace_retrace_start <= interlace_enable
			    && (char_count == HCNT_W'(ilace_q));
		end
	end

	// start compare wins would be ambiguous; end takes priority
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			tv_vdisp_en <= 1'b0;
		end else if (line_count ==
		             VCNT_W'({endhi_q[VDE_END_HI:0], endlo_q})) begin
			tv_vdisp_en <= 1'b0;
		end else if (line_count == VCNT_W'(vstart_q)) begin
			tv_vdisp_en <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// character clock: 8-dot chars, last one short
	// ---------------------------------------------------------------
	logic [3:0] dot_q;
	logic [3:0] char_dots;
	// codes below two are treated as a normal 8-dot line
	assign char_dots = (char_last && fine_q[CDOT_HI:0] >= CDOT_MIN)
	                   ? {1'b0, fine_q[CDOT_HI:0]} : FULL_CHAR;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dot_q <= 4'h0;
		end else if (dot_q + 4'h1 >= char_dots) begin
			dot_q <= 4'h0;
		end else begin
			dot_q <= dot_q + 4'h1;
		end
	end
	assign char_clk_en = (dot_q + 4'h1 >= char_dots);

	// ---------------------------------------------------------------
	// hsync delay line
	// ---------------------------------------------------------------
	logic [5:0] hs_pipe_q;
	logic [2:0] hs_dly;
	assign hs_dly = (fine_q[HSDLY_HI:HSDLY_LO] > HSDLY_MAX)
	                ? HSDLY_MAX : fine_q[HSDLY_HI:HSDLY_LO];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hs_pipe_q <= 6'h00;
		end else begin
			hs_pipe_q <= {hs_pipe_q[4:0], hsync_in};
		end
	end
	// tap zero is the input itself, so zero means no delay
	always_comb begin
		if (hs_dly == 3'h0) begin
			hsync_out = hsync_in;
		end else begin
			hsync_out = hs_pipe_q[hs_dly - 3'h1];
		end
	end

	// ---------------------------------------------------------------
	// equalizer / serration state machine
	// ---------------------------------------------------------------
	crtctv_eq_t eq_state_q;
	logic [7:0] eq_cnt_q;
	logic       hs_prev_q;
	logic [7:0] eq_len, serr_len;
	// width fields count in units of four video clocks
	assign eq_len   = 8'(eq_q[EQW_HI:0] * PULSE_UNIT);
	assign serr_len = 8'(serr_q[SERR_HI:0] * PULSE_UNIT);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hs_prev_q <= 1'b0;
		end else begin
			hs_prev_q <= hsync_in;
		end
	end
	// pulse per hsync edge; serration width inside vsync
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			eq_state_q <= CRTCTV_EQ_IDLE;
			eq_cnt_q   <= 8'h00;
		end else begin
			case (eq_state_q)
				CRTCTV_EQ_IDLE: begin
					if (hsync_in && !hs_prev_q) begin
						eq_state_q <= CRTCTV_EQ_PULSE;
						eq_cnt_q   <= vsync_in ? serr_len : eq_len;
					end
				end
				CRTCTV_EQ_PULSE: begin
					if (eq_cnt_q <= 8'h01) begin
						eq_state_q <= CRTCTV_EQ_GAP;
						eq_cnt_q   <= 8'h00;
					end else begin
						eq_cnt_q <= eq_cnt_q - 8'h01;
					end
				end
				CRTCTV_EQ_GAP: begin
					if (!hsync_in) begin
						eq_state_q <= CRTCTV_EQ_IDLE;
					end
				end
				default: eq_state_q <= CRTCTV_EQ_IDLE;
			endcase
		end
	end

	// composite sync is active low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			csync_out <= 1'b1;
		end else if (eq_q[CSYNC_SRC_BIT]) begin
			csync_out <= !(eq_state_q == CRTCTV_EQ_PULSE);
		end else begin
			csync_out <= !(hsync_in || vsync_in);
		end
	end

	// ---------------------------------------------------------------
	// ramdac blank and border
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dac_blank  <= 1'b1;
			border_sel <= 1'b0;
		end else if (test3_q[BLANK_SEL_BIT]) begin
			dac_blank  <= crt_blank;
			border_sel <= !crt_blank && !disp_en;
		end else begin
			dac_blank  <= !disp_en;
			border_sel <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_retrace_gate: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!$past(interlace_enable) |-> !interlace_retrace_start)
		else $error("retrace pulse without interlace");
	a_retrace_pos: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		interlace_enable && char_count == HCNT_W'(ilace_q)
		&& $stable(ilace_q) |=> interlace_retrace_start)
		else $error("retrace pulse missing");
	a_tv_end: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		line_count == VCNT_W'({endhi_q[2:0], endlo_q})
		|=> !tv_vdisp_en)
		else $error("tv enable not dropped");
	a_tv_start: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		line_count == VCNT_W'(vstart_q) && line_count !=
		VCNT_W'({endhi_q[2:0], endlo_q}) |=> tv_vdisp_en)
		else $error("tv enable not raised");
	a_csync_nor: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!eq_q[7] && (hsync_in || vsync_in) && $stable(eq_q)
		|=> !csync_out)
		else $error("csync not nor of syncs");
	a_hs_delay1: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		fine_q[5:3] == 3'h1 && $stable(fine_q)
		|-> hsync_out == $past(hsync_in))
		else $error("hsync delay one wrong");
	a_hs_nodelay: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		fine_q[5:3] == 3'h0 |-> hsync_out == hsync_in)
		else $error("hsync delay zero wrong");
	a_blank_inv: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		!test3_q[5] && $stable(test3_q) |=> dac_blank == !$past(disp_en)
		&& !border_sel)
		else $error("blank not inverse display");
	a_blank_crt: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		test3_q[5] && $stable(test3_q) |=> dac_blank == $past(crt_blank))
		else $error("blank not crt blank");
	a_lc_mask: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		test3_q[4] |-> line_compare_value[9:8] == 2'b00)
		else $error("line compare high not ignored");
	// a short final character may follow a full one, so it is exempt
	a_char_full: assert property (
		@(posedge clk_sys) disable iff (!rstn)
		char_clk_en && !char_last |=> (!char_clk_en || char_last) [*7])
		else $error("full character not eight dots");
	c_short_char: cover property (@(posedge clk_sys) disable iff (!rstn)
		char_last && char_clk_en && fine_q[2:0] == 3'h6);
	c_tv_window: cover property (@(posedge clk_sys) disable iff (!rstn)
		$rose(tv_vdisp_en) ##[1:1000] $fell(tv_vdisp_en));
	c_eq_pulse: cover property (@(posedge clk_sys) disable iff (!rstn)
		eq_q[7] && $fell(csync_out));
	c_border: cover property (@(posedge clk_sys) disable iff (!rstn)
		border_sel);

endmodule // crtctv_timing

// >>> verif/crtctv_encoder_model.sv
// ---------------------------------------------------------------
// tv encoder side: watches composite sync from the timing block
// ---------------------------------------------------------------
module crtctv_encoder_model
	import crtctv_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       csync_out,
	output logic      [7:0] low_width
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] run_q;
	logic [7:0] width_q;

	// encoder keeps the length of the last low sync pulse, in clocks
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			run_q   <= 8'h00;
			width_q <= 8'h00;
		end else if (!csync_out) begin
			run_q <= run_q + 8'h01; // wraps on very long lows, unused here
		end else begin
			if (run_q != 8'h00) begin
				width_q <= run_q;
			end
			run_q <= 8'h00;
		end
	end

	assign low_width = width_q;
endmodule // crtctv_encoder_model

// >>> verif/tb_top.sv
// ---------------------------------------------------------------
// register-level bench for the tv timing extensions
// ---------------------------------------------------------------
module tb_top
	import crtctv_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
	logic        misc_color_sel = 1'b1, interlace_enable = 1'b0;
	logic        vexpand_enable = 1'b0, vexpand_table_sel = 1'b0;
	logic        text_mode = 1'b0, char_last = 1'b0, crt_blank = 1'b0;
	logic        hsync_in = 1'b0, vsync_in = 1'b0, disp_en = 1'b0;
	logic [11:0] io_addr = 12'h000;
	logic [11:0] idx_port = PORT_IDX_COLOR, dat_port = PORT_DATA_COLOR;
	logic [7:0]  io_wdata = 8'h00, char_count = 8'h00;
	logic [7:0]  crtc_hblank_end_std = 8'h00, crtc_vblank_end_std = 8'h00;
	logic [9:0]  crtc_line_compare_std = 10'h3ff;
	logic [10:0] line_count = 11'h000;
	logic [15:0] dbg_val [4] = '{16'ha1a1, 16'hb2b2, 16'hc3c3, 16'hd4d4};
	logic [7:0]  io_rdata, hblank_end_value, low_width;
	logic        io_hit, interlace_retrace_start, interlace_timing_enable;
	logic        tv_vdisp_en, dda_from_constant, csync_out, hsync_out;
	logic        char_clk_en, dac_blank, border_sel;
	logic [9:0]  vblank_end_value, dda_value, line_compare_value;
	logic [2:0]  text_row_repeat;
	logic [15:0] debug_out;
	int          miscompares = 0, checked = 0, cycles = 0;

	crtctv_timing crtctv_timing_inst (
		.clk_sys, .rstn, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
		.io_hit, .misc_color_sel, .interlace_enable, .crtc_hblank_end_std,
		.crtc_vblank_end_std, .crtc_line_compare_std, .vexpand_enable,
		.vexpand_table_sel, .text_mode, .char_count, .char_last,
		.line_count, .hsync_in, .vsync_in, .crt_blank, .disp_en,
		.debug_bus_a(dbg_val[0]), .debug_bus_b(dbg_val[1]),
		.debug_bus_c(dbg_val[2]), .debug_bus_d(dbg_val[3]),
		.interlace_retrace_start, .interlace_timing_enable, .tv_vdisp_en,
		.hblank_end_value, .vblank_end_value, .dda_value, .text_row_repeat,
		.dda_from_constant, .csync_out, .hsync_out, .char_clk_en,
		.dac_blank, .border_sel, .line_compare_value, .debug_out
	);

	crtctv_encoder_model crtctv_encoder_model_inst (
		.clk_sys, .rstn, .csync_out, .low_width
	);

	// 20 mhz pixel clock
	always #25 clk_sys = ~clk_sys;

	// hang guard: the whole run needs well under 6000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// strobe held for one whole cycle, dropped at the taking edge
	task automatic io_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		io_addr  <= a;
		io_wdata <= d;
		io_wr    <= 1'b1;
		@(posedge clk_sys);
		io_wr <= 1'b0;
	endtask

	// read data is combinational, taken at the edge that ends the access
	task automatic io_read(input logic [11:0] a, output logic [7:0] d,
		output logic h);
		@(posedge clk_sys);
		io_addr <= a;
		io_rd   <= 1'b1;
		@(posedge clk_sys);
		d = io_rdata;
		h = io_hit;
		io_rd <= 1'b0;
	endtask

	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		io_write(idx_port, idx);
		io_write(dat_port, d);
	endtask

	task automatic reg_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		logic       h;
		io_write(idx_port, idx);
		io_read(dat_port, d, h);
		check($sformatf("reg %h", idx), 16'(d), 16'(exp));
	endtask

	// one registered stage after the driving edge
	task automatic settle();
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	// first gap only finds the phase; the last one is a whole character
	task automatic char_gap(output int n);
		int k;
		for (k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (char_clk_en !== 1'b1 && n < 20);
		end
	endtask

	function automatic logic [7:0] rw_mask(input int k);
		case (k)
			8'h36: return 8'h03;
			8'h38: return 8'hbf;
			8'h39, 8'h3a: return 8'h3f;
			default: return 8'hff;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0]  d;
		logic        h;
		int          n;
		logic [10:0] lv [7] = '{11'h120, 11'h00f, 11'h010, 11'h011,
			11'h020, 11'h120, 11'h121};
		logic        le [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		// reset values, writable bits, reserved bits reading zero
		for (int k = 8'h31; k <= 8'h3c; k++) begin
			if (k == 8'h37) continue;
			reg_chk(8'(k), 8'h00);
			if (k == 8'h3b) continue;
			reg_wr(8'(k), 8'hff);
			reg_chk(8'(k), rw_mask(k));
			reg_wr(8'(k), 8'h00);
		end
		reg_wr(8'h37, 8'h5a);
		reg_chk(8'h37, 8'h00);
		// split blank end values and the interlace timing bit
		crtc_hblank_end_std <= 8'h35;
		crtc_vblank_end_std <= 8'h5a;
		reg_wr(IDX_TV_VDE_ENDHI, 8'hcd);
		@(negedge clk_sys);
		check("ilace timing", 16'(interlace_timing_enable), 16'h0001);
		check("hblank end", 16'(hblank_end_value), 16'h00b5);
		check("vblank end", 16'(vblank_end_value), 16'h015a);
		// tv window: start 0x10, end 0x120 across the byte boundary
		reg_wr(IDX_TV_VDE_START, 8'h10);
		reg_wr(IDX_TV_VDE_ENDHI, 8'h01);
		reg_wr(IDX_TV_VDE_ENDLO, 8'h20);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk_sys);
			line_count <= lv[i];
			settle();
			check("tv vdisp", 16'(tv_vdisp_en), 16'(le[i]));
		end
		// retrace point honoured only with interlace on
		reg_wr(IDX_ILACE_RETRACE, 8'h2a);
		for (int ie = 0; ie < 2; ie++) begin
			@(posedge clk_sys);
			interlace_enable <= ie[0];
			char_count <= 8'h2a;
			settle();
			check("retrace", 16'(interlace_retrace_start), 16'(ie));
			@(posedge clk_sys);
			char_count <= 8'h2b;
			settle();
			check("retrace off", 16'(interlace_retrace_start), 16'h0);
		end
		// hsync delay codes, 7 clamps at the top
		for (int dl = 0; dl < 8; dl++) begin
			if (dl == 6) continue;
			reg_wr(IDX_FINE_TUNE, {2'b00, 3'(dl), 3'h0});
			@(posedge clk_sys);
			hsync_in <= 1'b1;
			n = 0;
			@(negedge clk_sys);
			while (hsync_out !== 1'b1 && n < 9) begin
				@(negedge clk_sys);
				n++;
			end
			check("hsync delay", 16'(n), 16'(dl > 5 ? 5 : dl));
			@(posedge clk_sys);
			hsync_in <= 1'b0;
			repeat (8) @(posedge clk_sys);
		end
		// short final character, every dot code
		for (int c = 0; c < 8; c++) begin
			reg_wr(IDX_FINE_TUNE, 8'(c));
			@(posedge clk_sys);
			char_last <= 1'b1;
			char_gap(n);
			check("char dots", 16'(n), 16'(c < 2 ? 8 : c));
		end
		@(posedge clk_sys);
		char_last <= 1'b0;
		char_gap(n);
		check("full char", 16'(n), 16'(FULL_CHAR));
		// composite sync: nor of syncs, then equalizer pulse widths
		reg_wr(IDX_EQ_CTRL, 8'h03);
		reg_wr(IDX_SERR_CTRL, 8'h05);
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_sys);
			hsync_in <= s[0];
			vsync_in <= s[1];
			settle();
			check("csync nor", 16'(csync_out), 16'(s == 0));
		end
		@(posedge clk_sys);
		hsync_in <= 1'b0;
		vsync_in <= 1'b0;
		// the equalizer pulse from the first hsync edge must run out first
		repeat (24) @(posedge clk_sys);
		reg_wr(IDX_EQ_CTRL, 8'h83);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk_sys);
			vsync_in <= v[0];
			hsync_in <= 1'b1;
			repeat (3) @(posedge clk_sys);
			hsync_in <= 1'b0;
			repeat (40) @(posedge clk_sys);
			check("csync width", 16'(low_width), 16'(v ? 20 : 12));
		end
		// blank select against all blank/display combinations
		for (int b = 0; b < 8; b++) begin
			if (b[1:0] == 2'b00) reg_wr(IDX_TEST_THREE, {2'b00, b[2], 5'h00});
			@(posedge clk_sys);
			crt_blank <= b[0];
			disp_en <= b[1];
			settle();
			check("dac blank", 16'(dac_blank),
				16'(b[2] ? b[0] : !b[1]));
			check("border", 16'(border_sel),
				16'(b[2] & !b[0] & !b[1]));
		end
		// debug bus select and line compare high-bit ignore
		for (int sel = 0; sel < 4; sel++) begin
			reg_wr(IDX_TEST_THREE, {2'(sel), 1'b0, sel[0], 4'h0});
			@(negedge clk_sys);
			check("debug bus", debug_out, dbg_val[sel]);
			check("line cmp", 16'(line_compare_value),
				16'(sel[0] ? 10'h0ff : 10'h3ff));
		end
		// expansion constant to dda and text row repeat
		reg_wr(IDX_VEXP_LO, 8'h9c);
		reg_wr(IDX_VEXP_HI, 8'hfe);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_sys);
			vexpand_enable <= 1'b1;
			vexpand_table_sel <= m[0];
			text_mode <= m[1];
			@(negedge clk_sys);
			check("dda", 16'(dda_value), 16'(m[0] ? 10'h0 : 10'h29c));
			check("dda src", 16'(dda_from_constant), 16'(!m[0]));
			check("row rep", 16'(text_row_repeat), 16'(m[1] ? 4 : 0));
		end
		// color base, then mono base
		for (int cs = 1; cs >= 0; cs--) begin
			@(posedge clk_sys);
			misc_color_sel <= cs[0];
			idx_port = cs ? PORT_IDX_COLOR : PORT_IDX_MONO;
			dat_port = cs ? PORT_DATA_COLOR : PORT_DATA_MONO;
			io_read(PORT_IDX_COLOR, d, h);
			check("hit color", 16'(h), 16'(cs));
			io_read(PORT_DATA_MONO, d, h);
			check("hit mono", 16'(h), 16'(!cs));
		end
		reg_chk(IDX_VEXP_LO, 8'h9c);
		wrap_up();
	end
endmodule // tb_top
